// ==== common/phy_ctl_pkg.sv ====
// Purpose: Shared constants and types for the basic mode control bits 9..6
// Assumes: Management frames arrive on the two-wire serial interface
// Notes: Offsets, field positions, reset values and frame lengths live here
package phy_ctl_pkg;
    // Register index of the basic mode control register
    localparam logic [4:0] BMC_REG_ADDR = 5'h00;
    // Field positions inside the control word
    localparam int BIT_AN_EN = 12;
    localparam int BIT_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    localparam int BIT_RSVD = 6;
    // Values after reset
    localparam logic RST_RESTART = 1'h0;
    localparam logic RST_DUPLEX = 1'h1;
    localparam logic RST_COL_TEST = 1'h0;
    // Frame layout
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] DATA_LAST = 4'hf;
    // Serial frame states
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_HDR, ST_TA, ST_DATA} mdio_state_t;
endpackage

// ==== src/sync_bank.sv ====
// Purpose: Two-stage synchroniser for a bank of pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First and second stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d_async;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== src/phy_ctl_bits.sv ====
// Purpose: Control bits 9..6 of the basic mode control register with serial access
// Assumes: MDC and MDIO are sampled on mclk, well faster than MDC
// Notes: Negotiation engine, enable bit and collision detect sit outside
//
// Function
// - Writing restart bit restarts auto-negotiation
// - Restart reads one until negotiation started
// - Restart ignored while auto-negotiation disabled
// - Writing zero never disturbs running negotiation
// - Negotiation off: duplex bit selects mode
// - Negotiation on: duplex reads resolved value
// - Collision test loops TX_EN onto COL
// - Reserved bit six reads zero always
// - Enable bit decides duplex bit role
// - Frames use read 10, write 01
`timescale 1ns/1ps
`default_nettype none
module phy_ctl_bits (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    input wire logic an_enable,
    input wire logic an_ack,
    input wire logic an_duplex_resolved,
    input wire logic tx_en,
    input wire logic col_in,
    output logic an_restart,
    output logic duplex_full,
    output logic col
);
    import phy_ctl_pkg::*;

    logic mdc_s, mdio_s, tx_en_s;
    logic [4:0] phy_addr_s;
    logic mdc_prev_q, mdc_rise;
    phy_ctl_pkg::mdio_state_t state_q;
    logic [5:0] ones_q;
    logic [3:0] cnt_q;
    logic [10:0] hdr_q;
    logic [11:0] hdr_full;
    logic hdr_match, is_read_q;
    logic [15:0] sh_q, wdat_q, rd_word;
    logic wr_stb_q;
    logic restart_q, restart_set;
    logic dup_forced_q, col_test_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    sync_bank #(.W(8)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d_async({mdc, mdio_i, tx_en, phy_addr}),
        .q({mdc_s, mdio_s, tx_en_s, phy_addr_s})
    );

    // Rising edge of the management clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mdc_prev_q <= 1'h0;
        end else begin
            mdc_prev_q <= mdc_s;
        end
    end
    assign mdc_rise = mdc_s & ~mdc_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Frame decode
    assign hdr_full = {hdr_q, mdio_s};
    assign hdr_match = (hdr_full[9:5] == phy_addr_s) &&
        ((hdr_full[11:10] == OP_READ) || (hdr_full[11:10] == OP_WRITE));

    // Read image of the control word
    always_comb begin
        rd_word = 16'h0000;
        rd_word[BIT_AN_EN] = an_enable;
        rd_word[BIT_RESTART] = restart_q;
        rd_word[BIT_DUPLEX] = an_enable ? an_duplex_resolved : dup_forced_q;
        rd_word[BIT_COL_TEST] = col_test_q;
        rd_word[BIT_RSVD] = 1'h0;
    end

    // Serial frame state machine, one step per MDC rising edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            ones_q <= 6'h00;
            cnt_q <= 4'h0;
            hdr_q <= 11'h000;
            is_read_q <= 1'h0;
            sh_q <= 16'h0000;
            wdat_q <= 16'h0000;
            wr_stb_q <= 1'h0;
            mdio_o <= 1'h0;
            mdio_oe <= 1'h0;
        end else begin
            wr_stb_q <= 1'h0;
            if (mdc_rise) begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (mdio_s) begin
                            ones_q <= (ones_q == PREAMBLE_ONES) ? ones_q : ones_q + 6'h01;
                        end else if (ones_q == PREAMBLE_ONES) begin
                            state_q <= ST_START;
                            ones_q <= 6'h00;
                        end else begin
                            ones_q <= 6'h00;
                        end
                    end
                    ST_START: begin
                        cnt_q <= 4'h0;
                        state_q <= mdio_s ? ST_HDR : ST_IDLE;
                    end
                    ST_HDR: begin
                        hdr_q <= hdr_full[10:0];
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == HDR_LAST) begin
                            cnt_q <= 4'h0;
                            is_read_q <= (hdr_full[11:10] == OP_READ);
                            sh_q <= (hdr_full[4:0] == BMC_REG_ADDR) ? rd_word : 16'h0000;
                            state_q <= hdr_match ? ST_TA : ST_IDLE;
                        end
                    end
                    ST_TA: begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h0) begin
                            mdio_oe <= is_read_q; // Second turnaround bit driven low
                            mdio_o <= 1'h0;
                        end else begin
                            cnt_q <= 4'h0;
                            state_q <= ST_DATA;
                            if (is_read_q) begin
                                mdio_o <= sh_q[15];
                                sh_q <= {sh_q[14:0], 1'h0};
                            end
                        end
                    end
                    ST_DATA: begin
                        cnt_q <= cnt_q + 4'h1;
                        wdat_q <= {wdat_q[14:0], mdio_s};
                        if (cnt_q == DATA_LAST) begin
                            state_q <= ST_IDLE;
                            mdio_oe <= 1'h0;
                            wr_stb_q <= ~is_read_q;
                        end else if (is_read_q) begin
                            mdio_o <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'h0};
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    logic wr0;
    assign wr0 = wr_stb_q && (hdr_q[4:0] == BMC_REG_ADDR);
    assign restart_set = wr0 && wdat_q[BIT_RESTART] && an_enable;

    // Restart request: set wins over acknowledge, zero writes ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            restart_q <= RST_RESTART;
        end else if (!an_enable) begin
            restart_q <= 1'h0;
        end else if (restart_set) begin
            restart_q <= 1'h1;
        end else if (an_ack) begin
            restart_q <= 1'h0;
        end
    end
    assign an_restart = restart_q;

    // Forced duplex and collision test bits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dup_forced_q <= RST_DUPLEX;
            col_test_q <= RST_COL_TEST;
        end else if (wr0) begin
            dup_forced_q <= wdat_q[BIT_DUPLEX];
            col_test_q <= wdat_q[BIT_COL_TEST];
        end
    end

    // Operating duplex and collision output
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            duplex_full <= RST_DUPLEX;
            col <= 1'h0;
        end else begin
            duplex_full <= an_enable ? an_duplex_resolved : dup_forced_q;
            col <= col_in | (col_test_q & tx_en_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_hdr_done;
        mdc_rise && state_q == ST_HDR && cnt_q == HDR_LAST && hdr_match;
    endsequence
    sequence s_write_end;
        mdc_rise && state_q == ST_DATA && cnt_q == DATA_LAST && !is_read_q;
    endsequence

    a_restart_set: assert property (restart_set |=> an_restart)
        else $error("restart write did not raise request");
    a_restart_hold: assert property (an_restart && !an_ack && an_enable |=> an_restart)
        else $error("restart bit dropped before acknowledge");
    a_restart_disabled: assert property (!an_enable |=> !an_restart)
        else $error("restart active while negotiation disabled");
    a_zero_write: assert property (wr0 && !wdat_q[BIT_RESTART] && an_restart && !an_ack
        && an_enable |=> an_restart)
        else $error("zero write cancelled restart");
    a_duplex_forced: assert property (!an_enable |=> duplex_full == $past(dup_forced_q))
        else $error("forced duplex not applied");
    a_duplex_read: assert property (an_enable |-> rd_word[BIT_DUPLEX] == an_duplex_resolved)
        else $error("duplex read not resolved value");
    a_col_test: assert property (col_test_q && tx_en_s |=> col)
        else $error("collision test did not assert col");
    a_reserved_zero: assert property (s_hdr_done |=>
        sh_q[BIT_RSVD] == 1'h0 && sh_q[15:13] == 3'h0)
        else $error("reserved bit read nonzero");
    a_hdr_accept: assert property (s_hdr_done |=> state_q == ST_TA)
        else $error("matched header did not enter turnaround");
    a_write_commit: assert property (s_write_end |=> wr_stb_q)
        else $error("write frame did not strobe");
    a_restart_clear: assert property (an_restart && an_ack && !restart_set |=> !an_restart)
        else $error("restart not cleared after acknowledge");
endmodule
`default_nettype wire

// ==== bench/mdio_mgr.sv ====
// Purpose: Station manager model driving MDC and MDIO frames
// Assumes: Released MDIO line is pulled high by the bench
// Notes: MDC half period is five mclk cycles, above the four needed
`timescale 1ns/1ps
`default_nettype none
module mdio_mgr (
    input wire logic mclk,
    input wire logic mdio,
    output logic mdc,
    output logic mdio_m,
    output logic mdio_m_oe
);
    import phy_ctl_pkg::*;
    ////////////////////////////////////////
    // Idle line, clock standing still
    initial begin
        mdc = 1'b0;
        mdio_m = 1'b0;
        mdio_m_oe = 1'b0;
    end
    // One MDC period: drive while low, sample just before the rise
    task automatic bit_cyc(input logic b, output logic s);
        @(negedge mclk);
        mdio_m = b;
        mdc = 1'b0;
        repeat (5) @(negedge mclk);
        s = mdio;
        mdc = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
    // Preamble, start, opcode and addresses
    task automatic hdr(input logic [1:0] op, input logic [4:0] pa);
        logic s;
        logic [13:0] h;
        h = {2'h1, op, pa, BMC_REG_ADDR};
        mdio_m_oe = 1'b1;
        repeat (32) bit_cyc(1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(h[i], s);
    endtask
    // Read frame: line released over the turnaround
    task automatic rd(input logic [4:0] pa, output logic [15:0] d);
        logic s;
        hdr(OP_READ, pa);
        mdio_m_oe = 1'b0;
        bit_cyc(1'b0, s);
        bit_cyc(1'b0, s);
        for (int i = 15; i >= 0; i--) bit_cyc(1'b0, d[i]);
    endtask
    // Write frame: turnaround 1 then 0, then the word
    task automatic wr(input logic [4:0] pa, input logic [15:0] d);
        logic s;
        hdr(OP_WRITE, pa);
        bit_cyc(1'b1, s);
        bit_cyc(1'b0, s);
        for (int i = 15; i >= 0; i--) bit_cyc(d[i], s);
        repeat (4) @(negedge mclk);
        mdio_m_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/phy_basic_control_bits_9_to_6_tb_top.sv ====
// Purpose: Register-level tests of control bits 9..6
// Assumes: Manager model supplies frames, bench drives the rest
// Notes: Inputs change on the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_bits_9_to_6_tb_top;
    import phy_ctl_pkg::*;
    localparam logic [4:0] PHY_ADDR = 5'h05;
    logic mclk, rst, mdc, mdio_m, mdio_m_oe, mdio_o, mdio_oe, mdio;
    logic an_enable, an_ack, an_dup, tx_en, col_in, an_restart, duplex_full, col;
    logic [15:0] rdat;
    int error_cnt = 0;
    int n_checks = 0;
    ////////////////////////////////////////
    // Clock, shared line with pull-up, instances
    always #12.5 mclk = ~mclk;
    assign mdio = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'b1);
    mdio_mgr mgr_u (.mclk(mclk), .mdio(mdio), .mdc(mdc), .mdio_m(mdio_m),
        .mdio_m_oe(mdio_m_oe));
    phy_ctl_bits dut_u (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_i(mdio),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(PHY_ADDR),
        .an_enable(an_enable), .an_ack(an_ack), .an_duplex_resolved(an_dup),
        .tx_en(tx_en), .col_in(col_in), .an_restart(an_restart),
        .duplex_full(duplex_full), .col(col));
    ////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [15:0] exp);
        mgr_u.rd(PHY_ADDR, rdat);
        chk(rdat, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Watchdog, well past the expected run length
    initial begin
        #1_000_000;
        error_cnt++;
        finish_test();
    end
    // Test sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        an_enable = 1'b0;
        an_ack = 1'b0;
        an_dup = 1'b0;
        tx_en = 1'b0;
        col_in = 1'b0;
        tick(10);
        rst = 1'b0;
        tick(3);
        chk({15'h0000, duplex_full}, 16'h0001);
        rchk(16'h0100);
        mgr_u.wr(PHY_ADDR, 16'h0300);
        tick(4);
        chk({15'h0000, an_restart}, 16'h0000);
        mgr_u.wr(PHY_ADDR, 16'h0000);
        tick(4);
        chk({15'h0000, duplex_full}, 16'h0000);
        rchk(16'h0000);
        mgr_u.rd(5'h1a, rdat);
        chk(rdat, 16'hffff);
        $display("test forced_mode done");
        // Collision loopback on and off
        mgr_u.wr(PHY_ADDR, 16'h0180);
        tx_en = 1'b1;
        tick(6);
        chk({15'h0000, col}, 16'h0001);
        tx_en = 1'b0;
        tick(6);
        chk({15'h0000, col}, 16'h0000);
        mgr_u.wr(PHY_ADDR, 16'h0100);
        tx_en = 1'b1;
        tick(6);
        chk({15'h0000, col}, 16'h0000);
        // Normal collision still passes with the test mode off
        col_in = 1'b1;
        tick(2);
        chk({15'h0000, col}, 16'h0001);
        col_in = 1'b0;
        tx_en = 1'b0;
        $display("test collision done");
        // Negotiated duplex and restart handshake
        an_enable = 1'b1;
        tick(3);
        chk({15'h0000, duplex_full}, 16'h0000);
        rchk(16'h1000);
        an_dup = 1'b1;
        mgr_u.wr(PHY_ADDR, 16'h0200);
        tick(4);
        chk({15'h0000, an_restart}, 16'h0001);
        rchk(16'h1300);
        mgr_u.wr(PHY_ADDR, 16'h0100);
        tick(4);
        chk({15'h0000, an_restart}, 16'h0001);
        an_ack = 1'b1;
        tick(3);
        chk({15'h0000, an_restart}, 16'h0000);
        an_ack = 1'b0;
        rchk(16'h1100);
        $display("test negotiation done");
        finish_test();
    end
endmodule
`default_nettype wire
